// file: rtl/wams_top.sv
// weld auxiliary sequencer: brazing, squeeze delay and retraction valve control
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module wams_top #(
  parameter int unsigned STUCK_CYC = wams_pkg::STUCK_LINE,
  parameter int unsigned BLINK_CYC = wams_pkg::BLINK_LINE
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic line_zc_i,
  input wire logic init_stage1_i,
  input wire logic init_stage2_i,
  input wire logic retract_input_n_i,
  output logic main_valve_o,
  output logic weld_current_o,
  output logic third_valve_out_o,
  output logic squeeze_led_o,
  output logic third_valve_led_o,
  output logic prog_mode_o,
  output logic [7:0] error_code_o
);

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  wams_pkg::wams_pins_t raw;
  wams_pkg::wams_pins_t s1_q, s2_q, s3_q, pin_q, pin_prev_q;
  assign raw = '{zc: line_zc_i, init1: init_stage1_i,
                 init2: init_stage2_i, retr: ~retract_input_n_i};

  // three stages; a level is taken once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < $bits(wams_pkg::wams_pins_t); g++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          pin_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= raw[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            pin_q[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

  // previous filtered level for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_prev_q <= '0;
    end else begin
      pin_prev_q <= pin_q;
    end
  end

  logic tick, retr_open, init1_rise;
  assign tick = pin_q.zc & ~pin_prev_q.zc;
  assign retr_open = ~pin_q.retr & pin_prev_q.retr;
  assign init1_rise = pin_q.init1 & ~pin_prev_q.init1;

  ////////////////////////////////////////////////////////////////////////
  // register file
  logic [31:0] ctrl_q;
  wams_pkg::wams_sched_t sched_q;
  logic [7:0] sqdl_q;
  logic wr, rd;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

  // byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [1:0] brz;
  logic [7:0] rsel;
  logic repeat_en, prog_req, moment, maint;
  assign brz = ctrl_q[wams_pkg::BRZ_LSB +: 2];
  assign repeat_en = ctrl_q[wams_pkg::REP_BIT];
  assign prog_req = ctrl_q[wams_pkg::PRG_BIT];
  assign rsel = ctrl_q[wams_pkg::RSEL_LSB +: 8];
  assign moment = (rsel == wams_pkg::RSEL_MOMENT);
  assign maint = (rsel == wams_pkg::RSEL_MAINT);

  // configuration writes; a clear-error write is a self-clearing bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= wams_pkg::CTRL_RST;
      sched_q <= '0;
      sqdl_q <= '0;
    end else begin
      ctrl_q[wams_pkg::CLR_BIT] <= 1'b0;
      if (wr) begin
        if (wb_adr_i == wams_pkg::ADR_CTRL) begin
          ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i);
        end else if (wb_adr_i == wams_pkg::ADR_TIME) begin
          sched_q <= merge(sched_q, wb_dat_i, wb_sel_i);
        end else if (wb_adr_i == wams_pkg::ADR_SQDL && wb_sel_i[0]) begin
          sqdl_q <= wb_dat_i[7:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // retraction valve
  logic retr_on_q, armed_q, stuck_q;
  logic [3:0] fill_q;
  logic [$clog2(STUCK_CYC+1)-1:0] stuck_cnt_q;
  logic retr_active;
  assign retr_active = moment | maint;

  // stuck-closed watch, timed in line cycles
  always_ff @(posedge clk_i) begin
    if (rst_i || !moment || !pin_q.retr) begin
      stuck_cnt_q <= '0;
      stuck_q <= 1'b0;
    end else if (tick && !stuck_q) begin
      if (stuck_cnt_q == STUCK_CYC[$bits(stuck_cnt_q)-1:0] - 1'b1) begin
        stuck_q <= 1'b1;
      end
      stuck_cnt_q <= stuck_cnt_q + 1'b1;
    end
  end

  // switch must read open after reset; fill waits out the synchroniser's reset level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_q <= 1'b0;
      fill_q <= '0;
    end else begin
      fill_q <= {fill_q[2:0], 1'b1};
      if (fill_q[3] && !pin_q.retr && s2_q.retr == s3_q.retr) begin
        armed_q <= 1'b1;
      end
    end
  end

  // toggles on release so a held switch still toggles once it opens
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      retr_on_q <= 1'b0;
    end else if (moment) begin
      if (retr_open) begin
        retr_on_q <= ~retr_on_q;
      end
    end else if (maint) begin
      retr_on_q <= pin_q.retr & armed_q;
    end else begin
      retr_on_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // weld sequencer
  wams_pkg::wams_state_t st_q;
  logic [7:0] cnt_q;
  logic first_q, cur_q, valve_q;
  logic start_ok, refuse, done;
  assign start_ok = ~retr_active | retr_on_q;
  assign refuse = init1_rise & ~start_ok & (st_q == wams_pkg::S_IDLE);
  assign done = (cnt_q == '0);

  // interval counter: loaded on entry, counts down on line ticks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= wams_pkg::S_IDLE;
      cnt_q <= '0;
    end else begin
      if (!done && tick) begin
        cnt_q <= cnt_q - 1'b1;
      end
      case (st_q)
        wams_pkg::S_IDLE: begin
          if (pin_q.init1 && start_ok && !prog_mode_o) begin
            if (brz == wams_pkg::BRZ_MAN) begin
              st_q <= wams_pkg::S_MAN;
            end else if (sqdl_q != '0) begin
              st_q <= wams_pkg::S_SQDL;
              cnt_q <= sqdl_q;
            end else begin
              st_q <= wams_pkg::S_SQZ;
              cnt_q <= sched_q.squeeze;
            end
          end
        end
        wams_pkg::S_SQDL: begin
          if (brz == wams_pkg::BRZ_AUTO && !pin_q.init1) begin
            st_q <= wams_pkg::S_IDLE;
          end else if (done) begin
            st_q <= wams_pkg::S_SQZ;
            cnt_q <= sched_q.squeeze;
          end
        end
        wams_pkg::S_SQZ: begin
          // in auto braze, a beat during squeeze drops the sequence
          if (brz == wams_pkg::BRZ_AUTO && !pin_q.init1) begin
            st_q <= wams_pkg::S_IDLE;
          end else if (done) begin
            st_q <= wams_pkg::S_WELD;
            cnt_q <= sched_q.weld;
          end
        end
        wams_pkg::S_WELD: begin
          if ((brz == wams_pkg::BRZ_AUTO && !pin_q.init1) || done) begin
            st_q <= wams_pkg::S_HOLD;
            cnt_q <= sched_q.hold;
          end
        end
        wams_pkg::S_HOLD: begin
          if (done) begin
            if (repeat_en && pin_q.init1 && brz == wams_pkg::BRZ_NONE) begin
              st_q <= wams_pkg::S_OFF;
              cnt_q <= sched_q.off;
            end else begin
              st_q <= wams_pkg::S_IDLE;
            end
          end
        end
        wams_pkg::S_OFF: begin
          // later squeezes of a repeat series skip the delay
          if (done) begin
            if (pin_q.init1 && start_ok) begin
              st_q <= wams_pkg::S_SQZ;
              cnt_q <= sched_q.squeeze;
            end else begin
              st_q <= wams_pkg::S_IDLE;
            end
          end
        end
        wams_pkg::S_MAN: begin
          if (!pin_q.init1) begin
            st_q <= wams_pkg::S_IDLE;
          end
        end
        default: begin
          st_q <= wams_pkg::S_IDLE;
        end
      endcase
    end
  end

  // valve and current outputs are decoded from the registered state and reach the pins two cycles behind it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valve_q <= 1'b0;
      cur_q <= 1'b0;
      first_q <= 1'b0;
    end else begin
      valve_q <= (st_q == wams_pkg::S_SQZ) || (st_q == wams_pkg::S_WELD) ||
                 (st_q == wams_pkg::S_HOLD) || (st_q == wams_pkg::S_MAN);
      cur_q <= ((st_q == wams_pkg::S_WELD) && !done &&
                !(brz == wams_pkg::BRZ_AUTO && !pin_q.init1)) ||
               ((st_q == wams_pkg::S_MAN) && pin_q.init1 && pin_q.init2);
      first_q <= (st_q == wams_pkg::S_SQDL);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // program mode, errors and lamps
  // program mode is granted only while the retraction valve is off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_mode_o <= 1'b0;
    end else if (!prog_req) begin
      prog_mode_o <= 1'b0;
    end else if (!retr_on_q && st_q == wams_pkg::S_IDLE) begin
      prog_mode_o <= 1'b1;
    end
  end

  // a new error wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      error_code_o <= wams_pkg::ERR_NONE;
    end else if (refuse) begin
      error_code_o <= wams_pkg::ERR_RETR;
    end else if (stuck_q) begin
      error_code_o <= wams_pkg::ERR_STUCK;
    end else if (ctrl_q[wams_pkg::CLR_BIT]) begin
      error_code_o <= wams_pkg::ERR_NONE;
    end
  end

  // blink timer on line ticks; pwm on the system clock for dimming
  logic [$clog2(BLINK_CYC+1)-1:0] blink_cnt_q;
  logic blink_q;
  logic [2:0] pwm_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blink_cnt_q <= '0;
      blink_q <= 1'b0;
      pwm_q <= '0;
    end else begin
      pwm_q <= pwm_q + 1'b1;
      if (tick) begin
        if (blink_cnt_q == BLINK_CYC[$bits(blink_cnt_q)-1:0] - 1'b1) begin
          blink_cnt_q <= '0;
          blink_q <= ~blink_q;
        end else begin
          blink_cnt_q <= blink_cnt_q + 1'b1;
        end
      end
    end
  end

  // third-valve lamp shows blink only, never the steady output level; squeeze lamp is steady in squeeze, dimmed in delay
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      third_valve_led_o <= 1'b0;
      squeeze_led_o <= 1'b0;
      third_valve_out_o <= 1'b0;
      main_valve_o <= 1'b0;
      weld_current_o <= 1'b0;
    end else begin
      third_valve_led_o <= retr_on_q & blink_q;
      squeeze_led_o <= (st_q == wams_pkg::S_SQZ) ||
                       (first_q && pwm_q < wams_pkg::DIM_DUTY);
      third_valve_out_o <= retr_on_q;
      main_valve_o <= valve_q;
      weld_current_o <= cur_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wishbone answer: ack one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= '0;
      if (rd) begin
        if (wb_adr_i == wams_pkg::ADR_CTRL) begin
          wb_dat_o <= ctrl_q;
        end else if (wb_adr_i == wams_pkg::ADR_TIME) begin
          wb_dat_o <= sched_q;
        end else if (wb_adr_i == wams_pkg::ADR_SQDL) begin
          wb_dat_o <= {24'h00_0000, sqdl_q};
        end else if (wb_adr_i == wams_pkg::ADR_STAT) begin
          wb_dat_o[2:0] <= st_q;
          wb_dat_o[wams_pkg::ST_VALVE] <= main_valve_o;
          wb_dat_o[wams_pkg::ST_RETR] <= retr_on_q;
          wb_dat_o[wams_pkg::ST_CUR] <= weld_current_o;
          wb_dat_o[wams_pkg::ST_PROG] <= prog_mode_o;
          wb_dat_o[wams_pkg::ST_ERR_LSB +: 8] <= error_code_o;
        end
      end
    end
  end

endmodule

// file: shared/wams_pkg.sv
// package: constants, register map and types of the weld auxiliary sequencer
package wams_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  // register byte offsets
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_TIME = 4'h4;
  localparam logic [3:0] ADR_SQDL = 4'h8;
  localparam logic [3:0] ADR_STAT = 4'hc;
  // control fields
  localparam int BRZ_LSB = 0;
  localparam int REP_BIT = 4;
  localparam int PRG_BIT = 5;
  localparam int CLR_BIT = 6;
  localparam int RSEL_LSB = 8;
  // status fields
  localparam int ST_VALVE = 8;
  localparam int ST_RETR = 9;
  localparam int ST_CUR = 10;
  localparam int ST_PROG = 11;
  localparam int ST_ERR_LSB = 16;
  // retraction selector and brazing codes
  localparam logic [7:0] RSEL_MOMENT = 8'h08;
  localparam logic [7:0] RSEL_MAINT = 8'h09;
  localparam logic [1:0] BRZ_NONE = 2'h0;
  localparam logic [1:0] BRZ_AUTO = 2'h1;
  localparam logic [1:0] BRZ_MAN = 2'h2;
  // error codes shown on the display
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_STUCK = 8'h05;
  localparam logic [7:0] ERR_RETR = 8'h27;
  // line-cycle timing, lamp dimming duty and control reset value
  localparam int unsigned STUCK_LINE = 300;
  localparam int unsigned BLINK_LINE = 30;
  localparam logic [2:0] DIM_DUTY = 3'h3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    S_IDLE, S_SQDL, S_SQZ, S_WELD, S_HOLD, S_OFF, S_MAN
  } wams_state_t;

  // schedule intervals in line cycles
  typedef struct packed {
    logic [7:0] off;
    logic [7:0] hold;
    logic [7:0] weld;
    logic [7:0] squeeze;
  } wams_sched_t;

  // synchronised operator inputs
  typedef struct packed {
    logic zc;
    logic init1;
    logic init2;
    logic retr;
  } wams_pins_t;
endpackage

// file: test/wams_operator.sv
// operator side model: mains zero-cross source and the operator's contacts
`timescale 1ns/1ps
module wams_operator #(
  parameter int ZC_HALF = 8
) (
  input wire logic clk_i,
  input wire logic press1_i,
  input wire logic press2_i,
  input wire logic retr_closed_i,
  output logic line_zc_o,
  output logic init_stage1_o,
  output logic init_stage2_o,
  output logic retract_input_n_o
);
  int half_q = 0;
  logic zc_q = 1'b0;
  logic [2:0] pin_q = 3'b001;
  assign line_zc_o = zc_q;
  assign {init_stage1_o, init_stage2_o, retract_input_n_o} = pin_q;
  ////////////////////////////////////////////////////////////
  // mains runs free, so the zero-cross wave never stops between welds
  always @(posedge clk_i) begin
    half_q <= (half_q == ZC_HALF - 1) ? 0 : half_q + 1;
    if (half_q == ZC_HALF - 1) begin
      zc_q <= ~zc_q;
    end
  end
  // two-stage initiation contacts; retraction line is pulled up, open reads high
  always @(posedge clk_i) begin
    pin_q <= {press1_i, press2_i, ~retr_closed_i};
  end
endmodule

// file: test/wams_checker_sva.sv
// concurrent checks on the weld auxiliary sequencer ports
`timescale 1ns/1ps
module wams_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic init_stage1_i,
  input wire logic init_stage2_i,
  input wire logic retract_input_n_i,
  input wire logic main_valve_o,
  input wire logic weld_current_o,
  input wire logic third_valve_out_o,
  input wire logic third_valve_led_o,
  input wire logic prog_mode_o
);
  logic [1:0] brz_q;
  logic [7:0] rsel_q;
  logic open_q;
  logic [3:0] rel_q;
  logic ctrl_wr;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////
  // a write is taken while the request is up and ack not yet given
  assign ctrl_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 4'h0;
  // shadow of the mode fields, since the register itself is hidden
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brz_q <= 2'h0;
      rsel_q <= 8'h00;
    end else if (ctrl_wr) begin
      brz_q <= wb_sel_i[0] ? wb_dat_i[1:0] : brz_q;
      rsel_q <= wb_sel_i[1] ? wb_dat_i[15:8] : rsel_q;
    end
  end
  // raw switch seen open since reset; the filtered view inside lags it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      open_q <= 1'b0;
    end else if (retract_input_n_i) begin
      open_q <= 1'b1;
    end
  end
  // cycles since the retraction switch was last released, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rel_q <= 4'hf;
    end else if ($rose(retract_input_n_i)) begin
      rel_q <= 4'h0;
    end else if (rel_q != 4'hf) begin
      rel_q <= rel_q + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////
  man_braze_a: assert property ((brz_q == wams_pkg::BRZ_MAN
      && $stable({init_stage1_i, init_stage2_i}))[*8] |-> main_valve_o == init_stage1_i
      && weld_current_o == (init_stage1_i && init_stage2_i)) else $error("manual braze bad");
  auto_stop_a: assert property (brz_q == wams_pkg::BRZ_AUTO && weld_current_o
      && $fell(init_stage1_i) |-> ##8 !weld_current_o && main_valve_o) else $error("no hold");
  cur_valve_a: assert property (weld_current_o |-> main_valve_o)
      else $error("current with open electrodes");
  refuse_init_a: assert property (rsel_q == wams_pkg::RSEL_MOMENT
      && $rose(main_valve_o) |-> third_valve_out_o) else $error("initiation not refused");
  mom_toggle_a: assert property (rsel_q == wams_pkg::RSEL_MOMENT
      && $changed(third_valve_out_o) |-> rel_q inside {[4'h2:4'hc]}) else $error("bad toggle");
  maint_follow_a: assert property ((rsel_q == wams_pkg::RSEL_MAINT && open_q
      && $stable(retract_input_n_i))[*8] |-> third_valve_out_o == !retract_input_n_i)
      else $error("valve not following switch");
  power_lock_a: assert property (rsel_q == wams_pkg::RSEL_MAINT
      && $rose(third_valve_out_o) |-> open_q) else $error("valve on before switch opened");
  prog_refuse_a: assert property ($rose(prog_mode_o) |-> !third_valve_out_o)
      else $error("program mode with valve on");
  led_off_a: assert property ((!third_valve_out_o)[*4] |-> !third_valve_led_o)
      else $error("valve lamp lit with valve off");
  cover property (brz_q == wams_pkg::BRZ_MAN && weld_current_o);
  cover property (rsel_q == wams_pkg::RSEL_MOMENT && $rose(third_valve_out_o));
  cover property (rsel_q == wams_pkg::RSEL_MAINT && third_valve_out_o);
endmodule
bind wams_top wams_checker i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_ack_o, .init_stage1_i, .init_stage2_i, .retract_input_n_i,
  .main_valve_o, .weld_current_o, .third_valve_out_o, .third_valve_led_o, .prog_mode_o);

// file: test/weld_aux_mode_sequencer_test.sv
// self-checking bench for the weld auxiliary mode sequencer
`timescale 1ns/1ps
module weld_aux_mode_sequencer_test;
  localparam int LP = 16;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, p1, p2, rc;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic wb_ack_o, line_zc_i, init_stage1_i, init_stage2_i, retract_input_n_i;
  logic main_valve_o, weld_current_o, third_valve_out_o, squeeze_led_o;
  logic third_valve_led_o, prog_mode_o;
  logic [7:0] error_code_o;
  int fail_count = 0;
  int tests_run = 0;
  int cnt, hi_n;
  // short stuck and blink counts keep the run brief
  wams_top #(.STUCK_CYC(3), .BLINK_CYC(2)) i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .line_zc_i,
    .init_stage1_i, .init_stage2_i, .retract_input_n_i, .main_valve_o, .weld_current_o,
    .third_valve_out_o, .squeeze_led_o, .third_valve_led_o, .prog_mode_o, .error_code_o);
  wams_operator #(.ZC_HALF(LP / 2)) i_op (.clk_i, .press1_i(p1), .press2_i(p2),
    .retr_closed_i(rc), .line_zc_o(line_zc_i), .init_stage1_o(init_stage1_i),
    .init_stage2_o(init_stage2_i), .retract_input_n_o(retract_input_n_i));
  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("compares %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chkr(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("wrong value at %0t: got %h, expected %h to %h", $time, got, lo, hi);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic done(input string s);
    $display("test %s ended", s);
  endtask
  // one classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    chk(n < 20, 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return main_valve_o;
      1: return weld_current_o;
      default: return third_valve_out_o;
    endcase
  endfunction
  // bounded wait on an output; also counts lit cycles of the squeeze lamp
  task automatic wt(input int k, input logic v);
    cnt = 0;
    hi_n = 0;
    while (pick(k) !== v && cnt < 400) begin
      @(posedge clk_i);
      cnt++;
      hi_n += squeeze_led_o;
    end
    chk(cnt < 400, 1'b1);
  endtask
  // hang guard, well beyond the few thousand cycles the tests need
  initial begin
    tick(30000);
    fail_count++;
    report_and_stop();
  end
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, p1, p2, rc} = 7'h40;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0000_0000;
    tick(3);
    rst_i <= 1'b0;
    tick(2);
    wb(1'b0, wams_pkg::ADR_CTRL, 32'h0000_0000);
    chk(rd, wams_pkg::CTRL_RST);
    wb(1'b1, wams_pkg::ADR_STAT, 32'hffff_ffff);
    wb(1'b0, wams_pkg::ADR_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    wb(1'b0, 4'h1, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    done("registers");
    wb(1'b1, wams_pkg::ADR_TIME, 32'h0000_6300);
    wb(1'b0, wams_pkg::ADR_TIME, 32'h0000_0000);
    chk(rd, 32'h0000_6300);
    wb(1'b1, wams_pkg::ADR_CTRL, 32'h0000_0002);
    p1 <= 1'b1;
    tick(12);
    chk({main_valve_o, weld_current_o}, 2'b10);
    for (int i = 0; i < 2; i++) begin
      p2 <= 1'b1;
      tick(12);
      chk({main_valve_o, weld_current_o}, 2'b11);
      p2 <= 1'b0;
      tick(12);
      chk({main_valve_o, weld_current_o}, 2'b10);
    end
    p1 <= 1'b0;
    tick(12);
    chk(main_valve_o, 1'b0);
    done("manual braze");
    wb(1'b1, wams_pkg::ADR_TIME, 32'h0004_3202);
    wb(1'b1, wams_pkg::ADR_CTRL, 32'h0000_0001);
    p1 <= 1'b1;
    wt(1, 1'b1);
    tick(40);
    p1 <= 1'b0;
    tick(10);
    chk({main_valve_o, weld_current_o}, 2'b10);
    wt(0, 1'b0);
    chkr(cnt, 2 * LP, 5 * LP);
    wb(1'b1, wams_pkg::ADR_TIME, 32'h0002_0302);
    p1 <= 1'b1;
    wt(1, 1'b1);
    wt(0, 1'b0);
    chkr(cnt, 3 * LP, 6 * LP + 8);
    p1 <= 1'b0;
    tick(40);
    done("auto braze");
    wb(1'b1, wams_pkg::ADR_CTRL, 32'h0000_0010);
    wb(1'b1, wams_pkg::ADR_TIME, 32'h0202_0202);
    for (int d = 0; d < 4; d += 3) begin
      wb(1'b1, wams_pkg::ADR_SQDL, d);
      p1 <= 1'b1;
      wt(0, 1'b1);
      chkr(cnt, d ? (d - 1) * LP : 0, d * LP + 14);
      if (d) begin
        chk(hi_n > 0 && hi_n * 2 < cnt, 1'b1);
      end
      wt(0, 1'b0);
      wt(0, 1'b1);
      chkr(cnt, LP, 3 * LP + 14);
      p1 <= 1'b0;
      wt(0, 1'b0);
      tick(20);
    end
    done("squeeze delay");
    wb(1'b1, wams_pkg::ADR_CTRL, 32'h0000_0800);
    p1 <= 1'b1;
    tick(12);
    chk({main_valve_o, error_code_o}, {1'b0, wams_pkg::ERR_RETR});
    p1 <= 1'b0;
    tick(12);
    wb(1'b1, wams_pkg::ADR_CTRL, 32'h0000_0840);
    tick(2);
    chk(error_code_o, wams_pkg::ERR_NONE);
    rc <= 1'b1;
    tick(8);
    rc <= 1'b0;
    tick(12);
    chk(third_valve_out_o, 1'b1);
    wb(1'b0, wams_pkg::ADR_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0200);
    cnt = 0;
    repeat (128) begin
      tick(1);
      cnt += third_valve_led_o;
    end
    chkr(cnt, 32, 96);
    wb(1'b1, wams_pkg::ADR_CTRL, 32'h0000_0820);
    tick(4);
    chk(prog_mode_o, 1'b0);
    wb(1'b1, wams_pkg::ADR_CTRL, 32'h0000_0800);
    p1 <= 1'b1;
    wt(1, 1'b1);
    p1 <= 1'b0;
    wt(0, 1'b0);
    chk(third_valve_out_o, 1'b1);
    rc <= 1'b1;
    tick(6 * LP);
    chk({third_valve_out_o, error_code_o}, {1'b1, wams_pkg::ERR_STUCK});
    rc <= 1'b0;
    tick(12);
    chk(third_valve_out_o, 1'b0);
    wb(1'b1, wams_pkg::ADR_CTRL, 32'h0000_0820);
    tick(4);
    chk(prog_mode_o, 1'b1);
    done("momentary retraction");
    rc <= 1'b1;
    rst_i <= 1'b1;
    tick(3);
    rst_i <= 1'b0;
    tick(2);
    wb(1'b1, wams_pkg::ADR_TIME, 32'h0202_0202);
    wb(1'b1, wams_pkg::ADR_CTRL, 32'h0000_0900);
    tick(20);
    chk(third_valve_out_o, 1'b0);
    rc <= 1'b0;
    tick(12);
    rc <= 1'b1;
    tick(12);
    chk(third_valve_out_o, 1'b1);
    p1 <= 1'b1;
    wt(1, 1'b1);
    p1 <= 1'b0;
    wt(0, 1'b0);
    chk(third_valve_out_o, 1'b1);
    rc <= 1'b0;
    tick(12);
    chk(third_valve_out_o, 1'b0);
    done("maintained retraction");
    report_and_stop();
  end
endmodule
